// file: hdl/cbsr_cfg.svh
/*
 * constants of the socket configuration register bank: offsets, field
 * positions, reset values and write masks.
 * assumes a configuration access port with dword addresses and byte enables.
 */
`ifndef CBSR_CFG_SVH
`define CBSR_CFG_SVH

`define CBSR_NUM_SOCK        2
`define CBSR_OFS_RETRY       8'h90
`define CBSR_OFS_CARD_CTRL   8'h91
`define CBSR_OFS_DEV_CTRL    8'h92
`define CBSR_OFS_FIFO_CTRL   8'h93
`define CBSR_OFS_DMA_REQ     8'h94
`define CBSR_OFS_DMA_BASE    8'h98

`define CBSR_RETRY_PCI_EN    7
`define CBSR_RETRY_CB_EN     6
`define CBSR_RETRY_FLAGS_W   6
`define CBSR_CC_RING_EN      7
`define CBSR_CC_ZOOM         6
`define CBSR_CC_PCI_INT_EN   5
`define CBSR_CC_FUNC_ROUTE   4
`define CBSR_CC_CSC_ROUTE    3
`define CBSR_CC_SPKR_SEL     1
`define CBSR_CC_IFG          0
`define CBSR_DC_5V           6
`define CBSR_DC_3V           5

`define CBSR_DEV_CTRL_RST    8'h70
`define CBSR_DEV_CTRL_WMASK  8'h7e
`define CBSR_FIFO_WMASK      8'h1f
`define CBSR_CC_SOCK_WMASK   8'h7a
`define CBSR_DMA_BASE_MSB    15
`define CBSR_DMA_BASE_LSB    4
`define CBSR_IO_UPPER_W      16

`endif

// file: hdl/cbsr_pkg.sv
/*
 * types of the socket configuration register bank.
 * assumes nothing beyond the constants header.
 */
package cbsr_pkg;
    typedef enum logic [1:0] {
        CBSR_IRQ_NONE   = 2'h0,
        CBSR_IRQ_ISA    = 2'h1,
        CBSR_IRQ_SERIAL = 2'h2,
        CBSR_IRQ_RSVD   = 2'h3
    } cbsr_irq_mode_e;

    typedef enum logic [1:0] {
        CBSR_DREQ_OFF   = 2'h0,
        CBSR_DREQ_SPKR  = 2'h1,
        CBSR_DREQ_INPK  = 2'h2,
        CBSR_DREQ_RSVD  = 2'h3
    } cbsr_dreq_pin_e;

    typedef enum logic [1:0] {
        CBSR_DMA_8BIT   = 2'h0,
        CBSR_DMA_16BIT  = 2'h1,
        CBSR_DMA_RSVD2  = 2'h2,
        CBSR_DMA_RSVD3  = 2'h3
    } cbsr_dma_width_e;

    typedef logic [11:0] cbsr_dma_base_t;
endpackage : cbsr_pkg

// file: hdl/cbsr_dma_decode.sv
/*
 * DMA register window decoder for one socket.
 * assumes io_addr/io_valid are synchronous to core_clk; answers one cycle later.
 */
`timescale 1ns/1ps
`include "cbsr_cfg.svh"

module cbsr_dma_decode (
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    input  wire cbsr_pkg::cbsr_dma_base_t base,
    input  wire logic                    decode_en,
    input  wire logic [31:0]             io_addr,
    input  wire logic                    io_valid,
    output logic                         hit
);
    logic upper_zero;
    logic hit_next;

    assign upper_zero = (io_addr[31:`CBSR_IO_UPPER_W] == 16'h0000);
    // decode gated by enable; low nibble is don't-care inside the 16-byte window
    assign hit_next = io_valid & decode_en & upper_zero &
        (io_addr[`CBSR_DMA_BASE_MSB:`CBSR_DMA_BASE_LSB] == base);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            hit <= 1'b0;
        end else begin
            hit <= hit_next;
        end
    end
endmodule : cbsr_dma_decode

// file: hdl/cbsr_regs.sv
/*
 * socket configuration register bank: retry status, per-socket card
 * control, shared device and FIFO control, per-socket DMA registers.
 * assumes a configuration port in core_clk: cfg_func picks the socket's
 * function, cfg_addr is a byte offset of a dword, cfg_be picks lanes.
 */
`timescale 1ns/1ps
`include "cbsr_cfg.svh"

module cbsr_regs (
    input  wire logic                   core_clk,
    input  wire logic                   srst,
    input  wire logic                   cfg_func,
    input  wire logic [7:0]             cfg_addr,
    input  wire logic [3:0]             cfg_be,
    input  wire logic                   cfg_wr,
    input  wire logic                   cfg_rd,
    input  wire logic [31:0]            cfg_wdata,
    output logic [31:0]                 cfg_rdata,
    output logic                        cfg_rvalid,
    input  wire logic [5:0]             retry_expire_in,
    output logic                        retry_pci_count_en,
    output logic                        retry_cb_count_en,
    input  wire logic [1:0]             card_func_irq,
    input  wire logic [1:0]             card_status_change,
    input  wire logic                   ring_indicate_in,
    input  wire logic [1:0]             card_spkr,
    output logic [1:0]                  int_pin_out,
    output logic [1:0]                  int_pin_oe_n,
    output logic                        ring_pin_mode,
    output logic                        ring_indicate_output,
    output logic                        host_speaker_output,
    output logic [1:0]                  suspend_mode_en,
    output logic [1:0]                  zoom_video_en,
    output logic                        sock_5v_capable,
    output logic                        sock_3v_capable,
    output cbsr_pkg::cbsr_irq_mode_e    irq_signal_mode,
    output logic [3:0]                  fifo_one_deep,
    output logic [3:0]                  dreq_pin_sel,
    output logic [3:0]                  dma_width_sel,
    input  wire logic [31:0]            io_addr,
    input  wire logic                   io_valid,
    output logic [1:0]                  dma_io_hit
);
    localparam int NS = `CBSR_NUM_SOCK;

    logic [1:0]  retry_en_reg;
    logic [5:0]  retry_flag_reg;
    logic [5:0]  retry_flag_next;
    logic [5:0]  retry_set;
    logic        ring_en_reg;
    logic [7:0]  card_ctrl_reg [NS];
    logic [7:0]  dev_ctrl_reg;
    logic [7:0]  fifo_ctrl_reg;
    logic [1:0]  dma_req_reg   [NS];
    logic [11:0] dma_base_reg  [NS];
    logic [1:0]  dma_width_reg [NS];
    logic [NS-1:0] dma_dec_en_reg;
    logic        wr_ctrl;
    logic        wr_dma_req;
    logic        wr_dma_base;
    logic [31:0] rdata_next;
    logic [1:0]  int_assert;
    logic [1:0]  spkr_route;

    assign wr_ctrl     = cfg_wr & (cfg_addr == `CBSR_OFS_RETRY);
    assign wr_dma_req  = cfg_wr & (cfg_addr == `CBSR_OFS_DMA_REQ);
    assign wr_dma_base = cfg_wr & (cfg_addr == `CBSR_OFS_DMA_BASE);

    assign retry_set = retry_expire_in &
        {{4{retry_en_reg[0]}}, {2{retry_en_reg[1]}}};

    always_comb begin
        retry_flag_next = retry_flag_reg;
        if (wr_ctrl && cfg_be[0]) begin
            retry_flag_next = retry_flag_reg & ~cfg_wdata[5:0];
        end
        retry_flag_next = retry_flag_next | retry_set;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            retry_en_reg   <= 2'h0;
            retry_flag_reg <= 6'h00;
        end else begin
            if (wr_ctrl && cfg_be[0]) begin
                retry_en_reg <= cfg_wdata[`CBSR_RETRY_PCI_EN:`CBSR_RETRY_CB_EN];
            end
            retry_flag_reg <= retry_flag_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ring_en_reg <= 1'b0;
        end else if (wr_ctrl && cfg_be[1]) begin
            ring_en_reg <= cfg_wdata[8 + `CBSR_CC_RING_EN];
        end
    end

    // shared device control; bits 7 and 0 stay zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dev_ctrl_reg <= `CBSR_DEV_CTRL_RST;
        end else if (wr_ctrl && cfg_be[2]) begin
            dev_ctrl_reg <= cfg_wdata[23:16] & `CBSR_DEV_CTRL_WMASK;
        end
    end

    // FIFO depth bits, top three read zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            fifo_ctrl_reg <= 8'h00;
        end else if (wr_ctrl && cfg_be[3]) begin
            fifo_ctrl_reg <= cfg_wdata[31:24] & `CBSR_FIFO_WMASK;
        end
    end

    genvar s;
    generate
        for (s = 0; s < NS; s++) begin : g_sock
            logic sel;
            assign sel = (cfg_func == s[0]);

            // per-socket card control, bit 2 held zero
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    card_ctrl_reg[s] <= 8'h00;
                end else begin
                    if (wr_ctrl && cfg_be[1] && sel) begin
                        card_ctrl_reg[s][6:1] <= cfg_wdata[14:9] & 6'h3d;
                        card_ctrl_reg[s][0]   <= card_func_irq[s] |
                            (card_ctrl_reg[s][0] & ~cfg_wdata[8]);
                    end else begin
                        card_ctrl_reg[s][0] <= card_ctrl_reg[s][0] | card_func_irq[s];
                    end
                    card_ctrl_reg[s][7] <= 1'b0;
                end
            end

            always_ff @(posedge core_clk) begin
                if (srst) begin
                    dma_req_reg[s]    <= 2'h0;
                    dma_base_reg[s]   <= 12'h000;
                    dma_width_reg[s]  <= 2'h0;
                    dma_dec_en_reg[s] <= 1'b0;
                end else begin
                    if (wr_dma_req && sel && cfg_be[0]) begin
                        dma_req_reg[s] <= cfg_wdata[1:0];
                    end
                    if (wr_dma_base && sel && cfg_be[0]) begin
                        dma_base_reg[s][3:0] <= cfg_wdata[7:4];
                        dma_width_reg[s]     <= cfg_wdata[2:1];
                        dma_dec_en_reg[s]    <= cfg_wdata[0];
                    end
                    if (wr_dma_base && sel && cfg_be[1]) begin
                        dma_base_reg[s][11:4] <= cfg_wdata[15:8];
                    end
                end
            end

            assign int_assert[s] = card_ctrl_reg[s][`CBSR_CC_PCI_INT_EN] &
                ((card_ctrl_reg[s][`CBSR_CC_FUNC_ROUTE] & card_func_irq[s]) |
                 (card_ctrl_reg[s][`CBSR_CC_CSC_ROUTE] & card_status_change[s]));
            assign spkr_route[s] = card_ctrl_reg[s][`CBSR_CC_SPKR_SEL] & card_spkr[s];

            always_ff @(posedge core_clk) begin
                if (srst) begin
                    int_pin_oe_n[s]    <= 1'b1;
                    int_pin_out[s]     <= 1'b0;
                    suspend_mode_en[s] <= 1'b1;
                    zoom_video_en[s]   <= 1'b0;
                    dreq_pin_sel[2*s +: 2]  <= 2'h0;
                    dma_width_sel[2*s +: 2] <= 2'h0;
                end else begin
                    // open-drain: pull low only while asserting
                    int_pin_oe_n[s]    <= ~int_assert[s];
                    int_pin_out[s]     <= 1'b0;
                    suspend_mode_en[s] <= ~card_ctrl_reg[s][`CBSR_CC_SPKR_SEL];
                    zoom_video_en[s]   <= card_ctrl_reg[s][`CBSR_CC_ZOOM];
                    dreq_pin_sel[2*s +: 2]  <= dma_req_reg[s];
                    dma_width_sel[2*s +: 2] <= dma_width_reg[s];
                end
            end

            cbsr_dma_decode u_dec (
                .core_clk  (core_clk),
                .srst      (srst),
                .base      (dma_base_reg[s]),
                .decode_en (dma_dec_en_reg[s]),
                .io_addr   (io_addr),
                .io_valid  (io_valid),
                .hit       (dma_io_hit[s])
            );
        end
    endgenerate

    // reserved bits read zero; unmapped dwords read zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (cfg_addr)
            `CBSR_OFS_RETRY: begin
                rdata_next = {fifo_ctrl_reg, dev_ctrl_reg,
                    ring_en_reg, card_ctrl_reg[cfg_func][6:0],
                    retry_en_reg, retry_flag_reg};
            end
            `CBSR_OFS_DMA_REQ: begin
                rdata_next = {30'h0000_0000, dma_req_reg[cfg_func]};
            end
            `CBSR_OFS_DMA_BASE: begin
                rdata_next = {16'h0000, dma_base_reg[cfg_func], 1'b0,
                    dma_width_reg[cfg_func], dma_dec_en_reg[cfg_func]};
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_rdata  <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata <= rdata_next;
            end
        end
    end

    // shared outputs
    always_ff @(posedge core_clk) begin
        if (srst) begin
            retry_pci_count_en   <= 1'b0;
            retry_cb_count_en    <= 1'b0;
            ring_pin_mode        <= 1'b0;
            ring_indicate_output <= 1'b0;
            host_speaker_output  <= 1'b0;
            sock_5v_capable      <= 1'b1;
            sock_3v_capable      <= 1'b1;
            irq_signal_mode      <= cbsr_pkg::CBSR_IRQ_NONE;
            fifo_one_deep        <= 4'h0;
        end else begin
            retry_pci_count_en   <= retry_en_reg[1];
            retry_cb_count_en    <= retry_en_reg[0];
            ring_pin_mode        <= ring_en_reg;
            ring_indicate_output <= ring_en_reg & ring_indicate_in;
            host_speaker_output  <= |spkr_route;
            sock_5v_capable      <= dev_ctrl_reg[`CBSR_DC_5V];
            sock_3v_capable      <= dev_ctrl_reg[`CBSR_DC_3V];
            irq_signal_mode      <= cbsr_pkg::cbsr_irq_mode_e'(dev_ctrl_reg[2:1]);
            fifo_one_deep        <= fifo_ctrl_reg[3:0];
        end
    end

    // checks
    default clocking cb_clk @(posedge core_clk); endclocking
    default disable iff (srst);

    AST_RETRY_RESET: assert property (
        $fell(srst) |-> (retry_en_reg == 2'h0) && (retry_flag_reg == 6'h00))
        else $error("retry register not clear after reset");

    AST_FLAG_STICKY: assert property (
        (retry_flag_reg[0] && !(wr_ctrl && cfg_be[0] && cfg_wdata[0]))
        |=> retry_flag_reg[0])
        else $error("expiry flag dropped without a clear");

    AST_SET_WINS: assert property (
        (retry_set[5] && wr_ctrl && cfg_be[0] && cfg_wdata[5])
        |=> retry_flag_reg[5])
        else $error("set lost to clear");

    AST_RING_FOLLOW: assert property (
        ring_en_reg && $stable(ring_en_reg) |=>
        ring_indicate_output == $past(ring_indicate_in))
        else $error("ring output does not follow input");

    AST_INT_GATED: assert property (
        !card_ctrl_reg[0][`CBSR_CC_PCI_INT_EN] |=> int_pin_oe_n[0])
        else $error("interrupt driven while disabled");

    AST_FUNC_ROUTE: assert property (
        (card_ctrl_reg[1][5:4] == 2'h3 && card_func_irq[1]) |=> !int_pin_oe_n[1])
        else $error("functional interrupt not routed");

    AST_CSC_ROUTE: assert property (
        (card_ctrl_reg[0][5] && card_ctrl_reg[0][3] && card_status_change[0])
        |=> !int_pin_oe_n[0])
        else $error("status change not routed");

    AST_IFG_SET: assert property (
        card_func_irq[1] |=> card_ctrl_reg[1][`CBSR_CC_IFG])
        else $error("card interrupt flag not set");

    AST_DEV_SHARED: assert property (
        (wr_ctrl && cfg_be[2]) |=> ##1 (sock_5v_capable == $past(cfg_wdata[22], 2)))
        else $error("device control write not seen");

    AST_RSVD_ZERO: assert property (
        cfg_rvalid |-> (cfg_rdata[31:29] == 3'h0) || ($past(cfg_addr) != `CBSR_OFS_RETRY))
        else $error("reserved buffer bits not zero");

    AST_DMA_UPPER: assert property (
        (io_valid && io_addr[31:16] != 16'h0000) |=> dma_io_hit == 2'h0)
        else $error("decode above 64K");

    AST_EXPIRE_SETS: assert property (
        (retry_expire_in[1] && retry_en_reg[1]) |=> retry_flag_reg[1])
        else $error("enabled expiry did not set its flag");

    AST_ZOOM_EN: assert property (
        card_ctrl_reg[0][`CBSR_CC_ZOOM] |=> zoom_video_en[0])
        else $error("zoom video not enabled");

    AST_SUSPEND_SEL: assert property (
        card_ctrl_reg[0][`CBSR_CC_SPKR_SEL] |=> !suspend_mode_en[0])
        else $error("suspend still enabled with speaker routed");

    AST_CC_RSVD: assert property (
        (cfg_rvalid && ($past(cfg_addr) == `CBSR_OFS_RETRY)) |-> !cfg_rdata[10])
        else $error("reserved card control bit not zero");

    COV_SET_CLEAR: cover property (retry_set[0] && wr_ctrl && cfg_be[0] && cfg_wdata[0]);
    COV_RETRY_EXPIRE: cover property (retry_set[1] ##1 retry_flag_reg[1]);
    COV_INT_ROUTED: cover property (!int_pin_oe_n[0] ##1 !int_pin_oe_n[1]);
    COV_DMA_HIT: cover property (dma_io_hit[1]);
endmodule : cbsr_regs

// file: testbench/cbsr_host_model.sv
/*
 * configuration master standing in for the host bridge: byte-lane writes
 * and reads on the register bank's configuration port.
 * assumes tasks are entered just after a falling edge of core_clk.
 */
`timescale 1ns/1ps
`include "cbsr_cfg.svh"

module cbsr_host_model (
    input  wire logic        core_clk,
    output logic             cfg_func,
    output logic [7:0]       cfg_addr,
    output logic [3:0]       cfg_be,
    output logic             cfg_wr,
    output logic             cfg_rd,
    output logic [31:0]      cfg_wdata,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_rvalid
);
    initial begin
        cfg_func  = 1'b0;
        cfg_addr  = 8'h00;
        cfg_be    = 4'h0;
        cfg_wr    = 1'b0;
        cfg_rd    = 1'b0;
        cfg_wdata = 32'h0000_0000;
    end

    task automatic wr(input logic f, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        logic [31:0] v;
        v = d;
        if (a == `CBSR_OFS_RETRY) begin
            v[23] = 1'b0;
            v[20] = 1'b1;
            v[19] = 1'b0;
            v[28] = 1'b0;
        end
        cfg_func  = f;
        cfg_addr  = a;
        cfg_be    = be;
        cfg_wdata = v;
        cfg_wr    = 1'b1;
        @(negedge core_clk);
        cfg_wr    = 1'b0;
        // released data inverted so a stale value never reads as a match
        cfg_wdata = ~v;
        // one idle edge, so back-to-back calls never re-drive the strobe at once
        @(negedge core_clk);
    endtask : wr

    task automatic rd(input logic f, input logic [7:0] a, output logic [32:0] r);
        cfg_func = f;
        cfg_addr = a;
        cfg_rd   = 1'b1;
        @(negedge core_clk);
        // rvalid stands only in the cycle right after the edge that took the read
        r = {cfg_rvalid, cfg_rdata};
        cfg_rd   = 1'b0;
        @(negedge core_clk);
    endtask : rd
endmodule : cbsr_host_model

// file: testbench/tb.sv
/*
 * self-checking bench of the socket configuration register bank.
 * assumes the host model drives the configuration port; inputs change
 * on the falling edge of core_clk.
 */
`timescale 1ns/1ps
`include "cbsr_cfg.svh"

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
    logic                     core_clk = 1'b0;
    logic                     srst = 1'b1;
    logic                     cfg_func, cfg_wr, cfg_rd, cfg_rvalid;
    logic [7:0]               cfg_addr;
    logic [3:0]               cfg_be;
    logic [31:0]              cfg_wdata, cfg_rdata, io_addr;
    logic [5:0]               retry_expire_in;
    logic                     retry_pci_count_en, retry_cb_count_en;
    logic [1:0]               card_func_irq, card_status_change, card_spkr;
    logic                     ring_indicate_in, io_valid;
    logic [1:0]               int_pin_out, int_pin_oe_n, suspend_mode_en;
    logic [1:0]               zoom_video_en, dma_io_hit;
    logic                     ring_pin_mode, ring_indicate_output, host_speaker_output;
    logic                     sock_5v_capable, sock_3v_capable;
    cbsr_pkg::cbsr_irq_mode_e irq_signal_mode;
    logic [3:0]               fifo_one_deep, dreq_pin_sel, dma_width_sel;
    int                       n_errors = 0;
    int                       num_checks = 0;
    int                       cycles = 0;

    always #12.5 core_clk = ~core_clk;

    cbsr_host_model i_host (.core_clk(core_clk), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));

    cbsr_regs i_dut (.core_clk(core_clk), .srst(srst), .cfg_func(cfg_func),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .retry_expire_in(retry_expire_in), .retry_pci_count_en(retry_pci_count_en),
        .retry_cb_count_en(retry_cb_count_en), .card_func_irq(card_func_irq),
        .card_status_change(card_status_change), .ring_indicate_in(ring_indicate_in),
        .card_spkr(card_spkr), .int_pin_out(int_pin_out), .int_pin_oe_n(int_pin_oe_n),
        .ring_pin_mode(ring_pin_mode), .ring_indicate_output(ring_indicate_output),
        .host_speaker_output(host_speaker_output), .suspend_mode_en(suspend_mode_en),
        .zoom_video_en(zoom_video_en), .sock_5v_capable(sock_5v_capable),
        .sock_3v_capable(sock_3v_capable), .irq_signal_mode(irq_signal_mode),
        .fifo_one_deep(fifo_one_deep), .dreq_pin_sel(dreq_pin_sel),
        .dma_width_sel(dma_width_sel), .io_addr(io_addr), .io_valid(io_valid),
        .dma_io_hit(dma_io_hit));

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            summarize();
        end
    end

    // registered outputs lag a write by two edges
    task automatic settle();
        repeat (2) @(negedge core_clk);
    endtask : settle

    task automatic rchk(input logic f, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        logic [32:0] r;
        i_host.rd(f, a, r);
        `CHK({r[32], r[31:0] & m}, {1'b1, e})
    endtask : rchk

    task automatic pulse_expiry(input logic [5:0] v);
        retry_expire_in = v;
        @(negedge core_clk);
        retry_expire_in = 6'h00;
    endtask : pulse_expiry

    task automatic t_reset();
        rchk(1'b0, 8'h90, 32'hffff_ffff, 32'h0070_0000);
        rchk(1'b1, 8'h94, 32'hffff_ffff, 32'h0000_0000);
        rchk(1'b0, 8'h98, 32'hffff_ffff, 32'h0000_0000);
        `CHK({int_pin_oe_n, suspend_mode_en, zoom_video_en}, 6'h3c)
        `CHK({sock_5v_capable, sock_3v_capable, ring_pin_mode}, 3'h6)
        `CHK({retry_pci_count_en, retry_cb_count_en, irq_signal_mode}, 4'h0)
        `CHK({fifo_one_deep, dreq_pin_sel, dma_width_sel}, 12'h000)
    endtask : t_reset

    task automatic t_retry();
        i_host.wr(1'b0, 8'h90, 4'h1, 32'h0000_0080);
        settle();
        `CHK({retry_pci_count_en, retry_cb_count_en}, 2'b10)
        pulse_expiry(6'h3f);
        rchk(1'b0, 8'h90, 32'h0000_00ff, 32'h0000_0083);
        i_host.wr(1'b0, 8'h90, 4'h1, 32'h0000_00c0);
        pulse_expiry(6'h3f);
        rchk(1'b1, 8'h90, 32'h0000_00ff, 32'h0000_00ff);
        // a new expiry lands in the same cycle as its clear
        retry_expire_in = 6'h21;
        i_host.wr(1'b0, 8'h90, 4'h1, 32'h0000_00f5);
        retry_expire_in = 6'h00;
        rchk(1'b0, 8'h90, 32'h0000_00ff, 32'h0000_00eb);
        i_host.wr(1'b1, 8'h90, 4'h1, 32'h0000_003f);
        pulse_expiry(6'h3f);
        rchk(1'b0, 8'h90, 32'h0000_00ff, 32'h0000_0000);
    endtask : t_retry

    task automatic t_card();
        i_host.wr(1'b0, 8'h90, 4'h2, 32'h0000_ff00);
        rchk(1'b0, 8'h90, 32'h0000_ff00, 32'h0000_fa00);
        rchk(1'b1, 8'h90, 32'h0000_ff00, 32'h0000_8000);
        settle();
        `CHK({zoom_video_en, suspend_mode_en, ring_pin_mode}, 5'b01_10_1)
        ring_indicate_in = 1'b1;
        card_spkr = 2'b10;
        settle();
        `CHK({ring_indicate_output, host_speaker_output}, 2'b10)
        card_spkr = 2'b01;
        ring_indicate_in = 1'b0;
        settle();
        `CHK({ring_indicate_output, host_speaker_output}, 2'b01)
    endtask : t_card

    task automatic t_irq();
        i_host.wr(1'b1, 8'h90, 4'h2, 32'h0000_b000);
        card_func_irq = 2'b11;
        settle();
        `CHK({int_pin_oe_n, int_pin_out}, 4'b0000)
        card_func_irq = 2'b00;
        settle();
        rchk(1'b0, 8'h90, 32'h0000_ff00, 32'h0000_fb00);
        rchk(1'b1, 8'h90, 32'h0000_ff00, 32'h0000_b100);
        i_host.wr(1'b0, 8'h90, 4'h2, 32'h0000_fb00);
        rchk(1'b0, 8'h90, 32'h0000_ff00, 32'h0000_fa00);
        i_host.wr(1'b0, 8'h90, 4'h2, 32'h0000_a000);
        card_status_change = 2'b11;
        settle();
        `CHK(int_pin_oe_n, 2'b11)
        card_func_irq = 2'b01;
        settle();
        `CHK(int_pin_oe_n, 2'b11)
        card_func_irq = 2'b00;
        i_host.wr(1'b0, 8'h90, 4'h2, 32'h0000_a800);
        settle();
        `CHK(int_pin_oe_n, 2'b10)
        i_host.wr(1'b0, 8'h90, 4'h2, 32'h0000_9800);
        card_func_irq = 2'b01;
        settle();
        `CHK(int_pin_oe_n, 2'b11)
        card_func_irq = 2'b00;
        card_status_change = 2'b00;
    endtask : t_irq

    task automatic t_dev();
        logic [2:0] m;
        for (m = 3'd0; m < 3'd4; m++) begin
            i_host.wr(1'b1, 8'h90, 4'h4, {8'h00, 4'h1, 1'b0, m[1:0], 1'b0, 16'h0000});
            settle();
            `CHK({sock_5v_capable, sock_3v_capable, irq_signal_mode}, {2'b00, m[1:0]})
        end
        rchk(1'b0, 8'h90, 32'h00ff_0000, 32'h0016_0000);
        i_host.wr(1'b0, 8'h90, 4'h4, 32'h0071_0000);
        settle();
        `CHK({sock_5v_capable, sock_3v_capable}, 2'b11)
        rchk(1'b1, 8'h90, 32'h00ff_0000, 32'h0070_0000);
    endtask : t_dev

    task automatic t_fifo();
        i_host.wr(1'b0, 8'h90, 4'h8, 32'hff00_0000);
        settle();
        `CHK(fifo_one_deep, 4'hf)
        rchk(1'b1, 8'h90, 32'hff00_0000, 32'h0f00_0000);
        i_host.wr(1'b1, 8'h90, 4'h8, 32'h0500_0000);
        settle();
        `CHK(fifo_one_deep, 4'h5)
    endtask : t_fifo

    task automatic io(input logic [31:0] a, input logic [1:0] e);
        io_addr = a;
        io_valid = 1'b1;
        @(negedge core_clk);
        io_valid = 1'b0;
        io_addr = ~a;
        `CHK(dma_io_hit, e)
        @(negedge core_clk);
    endtask : io

    task automatic t_dma();
        logic [2:0] c;
        logic [1:0] s;
        for (s = 2'd0; s < 2'd2; s++) begin
            for (c = 3'd0; c < 3'd3; c++) begin
                i_host.wr(s[0], 8'h94, 4'hf, {30'h0, c[1:0]});
                settle();
                `CHK(dreq_pin_sel[2*s +: 2], c[1:0])
            end
        end
        i_host.wr(1'b0, 8'h98, 4'hf, 32'hffff_123b);
        i_host.wr(1'b1, 8'h98, 4'hf, 32'h0000_4564);
        rchk(1'b0, 8'h98, 32'hffff_ffff, 32'h0000_1233);
        rchk(1'b1, 8'h98, 32'hffff_ffff, 32'h0000_4564);
        settle();
        `CHK(dma_width_sel, 4'b1001)
        io(32'h0000_1230, 2'b01);
        io(32'h0000_123f, 2'b01);
        io(32'h0000_1240, 2'b00);
        io(32'h0000_122f, 2'b00);
        io(32'h0001_1230, 2'b00);
        io(32'h0000_4568, 2'b00);
        i_host.wr(1'b1, 8'h98, 4'h1, 32'h0000_0065);
        io(32'h0000_4568, 2'b10);
        i_host.wr(1'b0, 8'ha0, 4'hf, 32'hffff_ffff);
        rchk(1'b0, 8'ha0, 32'hffff_ffff, 32'h0000_0000);
    endtask : t_dma

    initial begin
        retry_expire_in = 6'h00;
        card_func_irq = 2'b00;
        card_status_change = 2'b00;
        card_spkr = 2'b00;
        ring_indicate_in = 1'b0;
        io_addr = 32'h0000_0000;
        io_valid = 1'b0;
        repeat (20) @(negedge core_clk);
        srst = 1'b0;
        t_reset();
        t_retry();
        t_card();
        t_irq();
        t_dev();
        t_fifo();
        t_dma();
        summarize();
    end
endmodule : tb
